// ### dv/dual_timer_monitor.sv
// Purpose: Port-level assertions for the dual down timer
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees top-level ports only; bound below the module
`timescale 1ns/1ns
module dual_timer_monitor
	import dual_timer_pkg::*;
#(
	parameter int LATCH_CYCLES = 20
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [dual_timer_pkg::ADDR_W-1:0] i_addr,
	input wire logic [dual_timer_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [dual_timer_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_t0_src_tick,
	input wire logic i_t1_src_tick,
	input wire logic i_tick_2048hz,
	input wire logic i_event_input_pin,
	input wire logic o_clock_out_pin,
	input wire logic o_inv_clock_out_pin,
	input wire logic o_t0_irq_flag,
	input wire logic o_t1_irq_flag,
	input wire logic [1:0] o_irq_level
);
	wire rd_ctl = i_rd && (i_addr == ADDR_T0_CTRL || i_addr == ADDR_T1_CTRL);
	wire rd_prio = i_rd && i_addr == ADDR_PRIORITY;
	wire wr_prio = i_wr && i_addr == ADDR_PRIORITY;
	wire rd_flag = i_rd && i_addr == ADDR_IRQ_FLAG;
	wire wr_flag = i_wr && i_addr == ADDR_IRQ_FLAG;
	wire wr_off = i_wr && i_addr == ADDR_GLOBAL && !i_wdata[BIT_OUT_EN];

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_preset_reads_zero: assert property (rd_ctl |=> o_rdata[BIT_PRESET] == 1'b0)
		else $error("preset bit read back as one");
	a_level_written: assert property (wr_prio |=> o_irq_level == $past(i_wdata[3:2]))
		else $error("priority level not taken from write");
	a_level_readback: assert property (rd_prio |=> o_rdata == {4'h0, $past(o_irq_level), 2'h0})
		else $error("priority readback wrong");
	a_pins_idle: assert property (wr_off |-> ##2 (o_clock_out_pin && !o_inv_clock_out_pin))
		else $error("clock pins not idle after disable");
	a_pins_complement: assert property (o_clock_out_pin != o_inv_clock_out_pin)
		else $error("clock pins not complementary");
	a_flag0_clear: assert property ($fell(o_t0_irq_flag) |-> $past(wr_flag && i_wdata[BIT_T0_FLAG]))
		else $error("timer 0 flag fell without clear");
	a_flag1_clear: assert property ($fell(o_t1_irq_flag) |-> $past(wr_flag && i_wdata[BIT_T1_FLAG]))
		else $error("timer 1 flag fell without clear");
	a_flag_readback: assert property (rd_flag |=> o_rdata == {$past(o_t1_irq_flag), $past(o_t0_irq_flag), 6'h00})
		else $error("flag readback wrong");

	c_t0_flag: cover property ($rose(o_t0_irq_flag));
	c_t1_flag: cover property ($rose(o_t1_irq_flag));
	c_clock_toggle: cover property ($rose(o_clock_out_pin));
	c_flag_read: cover property (rd_flag ##1 o_rdata[BIT_T0_FLAG]);
endmodule : dual_timer_monitor

bind dual_programmable_down_timer dual_timer_monitor #(.LATCH_CYCLES(LATCH_CYCLES)) mon (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_t0_src_tick(i_t0_src_tick), .i_t1_src_tick(i_t1_src_tick),
	.i_tick_2048hz(i_tick_2048hz), .i_event_input_pin(i_event_input_pin), .o_clock_out_pin(o_clock_out_pin),
	.o_inv_clock_out_pin(o_inv_clock_out_pin), .o_t0_irq_flag(o_t0_irq_flag), .o_t1_irq_flag(o_t1_irq_flag),
	.o_irq_level(o_irq_level)
);

// ### dv/event_source.sv
// Purpose: External pulse source on the event input pin
// Assumes: Pin has a pull-up, so it idles high
// Notes:   A start request makes one low pulse of i_width cycles
`timescale 1ns/1ns
module event_source (
	input wire logic i_ref_clk,
	input wire logic i_start,
	input wire logic [7:0] i_width,
	output logic o_pin
);
	logic [7:0] left_r = 8'h00;
	always @(posedge i_ref_clk) begin
		if (i_start)
			left_r <= i_width;
		else if (left_r != 8'h00)
			left_r <= left_r - 8'h01;
	end
	// Released pin returns to the pull-up level
	assign o_pin = (left_r == 8'h00);
endmodule : event_source

// ### dv/testbench.sv
// Purpose: Self-checking bench for the dual down timer
// Assumes: Source ticks driven one per cycle when enabled
// Notes:   Latch release shortened to 400 cycles
`timescale 1ns/1ns
module testbench;
	import dual_timer_pkg::*;
	logic i_ref_clk, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, tk = 1'b0, t2k = 1'b0, ev_go = 1'b0;
	logic pin_o, pin_n, pin_q, f0, f1, ev_pin;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00, o_rdata, ev_w = 8'h00, a, b;
	logic [2:0] div8 = 3'h0;
	logic [1:0] lvl;
	int n_fail = 0, checked = 0, cyc = 0, tog = 0, k;
	logic [15:0] ra [10] = '{ADDR_PRIORITY, ADDR_IRQ_FLAG, ADDR_GLOBAL, ADDR_T0_CTRL, ADDR_T1_CTRL,
		ADDR_T0_RELOAD, ADDR_T1_RELOAD, ADDR_T0_COUNT, ADDR_T1_COUNT, 16'hFF40};
	logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, RELOAD_RST, RELOAD_RST, COUNT_RST, COUNT_RST, 8'h00};

	dual_programmable_down_timer #(.LATCH_CYCLES(400)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_t0_src_tick(tk),
		.i_t1_src_tick(tk), .i_tick_2048hz(t2k), .i_event_input_pin(ev_pin), .o_clock_out_pin(pin_o),
		.o_inv_clock_out_pin(pin_n), .o_t0_irq_flag(f0), .o_t1_irq_flag(f1), .o_irq_level(lvl));
	event_source src (.i_ref_clk(i_ref_clk), .i_start(ev_go), .i_width(ev_w), .o_pin(ev_pin));

	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		div8 <= div8 + 3'h1;
		t2k <= (div8 == 3'h7);
		if (pin_o !== pin_q)
			tog++;
		pin_q <= pin_o;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] ad, output logic [7:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	task automatic rdc(input logic [15:0] ad, input logic [7:0] e);
		logic [7:0] d;
		rd(ad, d);
		chk($sformatf("reg %h", ad), e, d);
	endtask : rdc

	// Ends just after the edge so toggle windows line up
	task automatic ticks(input int n);
		repeat (n) @(posedge i_ref_clk) tk <= 1'b1;
		@(posedge i_ref_clk);
		tk <= 1'b0;
		#1;
	endtask : ticks

	// 64 ticks wrap the prescaler, so the step is independent of its phase
	task automatic measure(input logic [7:0] ctl, input logic [7:0] e);
		wr(ADDR_T0_CTRL, ctl);
		ticks(70);
		rd(ADDR_T0_COUNT, a);
		ticks(64);
		rd(ADDR_T0_COUNT, b);
		chk("t0 step", e, a - b);
	endtask : measure

	task automatic ev(input logic [7:0] w);
		@(posedge i_ref_clk);
		ev_go <= 1'b1;
		ev_w <= w;
		@(posedge i_ref_clk);
		ev_go <= 1'b0;
	endtask : ev

	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (k = 0; k < 10; k++) rdc(ra[k], rv[k]);
		chk("pins", 8'h02, {6'h00, pin_o, pin_n});
		wr(ADDR_T0_COUNT, 8'h55);
		rdc(ADDR_T0_COUNT, COUNT_RST);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_PRIORITY, 8'(k << 2));
			rdc(ADDR_PRIORITY, 8'(k << 2));
			chk("level", 8'(k), {6'h00, lvl});
		end
		for (k = 0; k < 4; k++) measure(8'(k * 8 + 3), 8'(64 >> (2 * k)));
		measure(8'h43, 8'h00);
		measure(8'h63, 8'h40);
		measure(8'h23, 8'h40);
		wr(ADDR_T0_CTRL, 8'h00);
		ticks(4);
		rdc(ADDR_T0_CTRL, 8'h00);
		rd(ADDR_T0_COUNT, a);
		ticks(8);
		rdc(ADDR_T0_COUNT, a);
		wr(ADDR_T0_RELOAD, 8'h03);
		wr(ADDR_T0_CTRL, 8'h02);
		rdc(ADDR_T0_COUNT, 8'h03);
		wr(ADDR_T0_CTRL, 8'h01);
		ticks(20);
		rdc(ADDR_T0_CTRL, 8'h00);
		rdc(ADDR_T0_COUNT, 8'h03);
		rdc(ADDR_IRQ_FLAG, 8'h40);
		chk("flag0 set", 8'h01, {7'h00, f0});
		wr(ADDR_IRQ_FLAG, 8'h40);
		rdc(ADDR_IRQ_FLAG, 8'h00);
		chk("flag0 clear", 8'h00, {7'h00, f0});
		wr(ADDR_GLOBAL, 8'h04);
		wr(ADDR_T0_CTRL, 8'h07);
		ticks(8);
		tog = 0;
		ticks(64);
		chk("toggles", 8'h10, 8'(tog));
		rdc(ADDR_T0_CTRL, 8'h05);
		wr(ADDR_GLOBAL, 8'h0C);
		#1 tog = 0;
		ticks(64);
		chk("toggles t1", 8'h00, 8'(tog));
		// Timer 1 one-shot in 8-bit mode drives the output clock once
		wr(ADDR_T1_RELOAD, 8'h01);
		wr(ADDR_T1_CTRL, 8'h03);
		#1 tog = 0;
		ticks(8);
		chk("t1 toggles", 8'h01, 8'(tog));
		chk("flag1 set", 8'h01, {7'h00, f1});
		rdc(ADDR_T1_CTRL, 8'h00);
		rdc(ADDR_T1_COUNT, 8'h01);
		wr(ADDR_T1_RELOAD, 8'hFF);
		wr(ADDR_T1_CTRL, 8'h02);
		wr(ADDR_GLOBAL, 8'h00);
		ticks(2);
		chk("pins off", 8'h02, {6'h00, pin_o, pin_n});
		wr(ADDR_T0_CTRL, 8'h00);
		ticks(4);
		wr(ADDR_T0_RELOAD, 8'hFF);
		for (k = 0; k < 2; k++) begin
			wr(ADDR_T0_CTRL, 8'h9B | 8'(k << 5));
			ev(8'h28);
			repeat (10) @(posedge i_ref_clk);
			rdc(ADDR_T0_COUNT, k ? 8'hFF : 8'hFE);
			repeat (40) @(posedge i_ref_clk);
			rdc(ADDR_T0_COUNT, 8'hFE);
		end
		wr(ADDR_T0_CTRL, 8'hC3);
		ev(8'h04);
		repeat (30) @(posedge i_ref_clk);
		rdc(ADDR_T0_COUNT, 8'hFF);
		ev(8'h28);
		repeat (60) @(posedge i_ref_clk);
		rdc(ADDR_T0_COUNT, 8'hFE);
		wr(ADDR_T0_CTRL, 8'h03);
		wr(ADDR_GLOBAL, 8'h10);
		wr(ADDR_IRQ_FLAG, 8'hC0);
		wr(ADDR_T1_CTRL, 8'h01);
		rdc(ADDR_T1_CTRL, 8'h00);
		ticks(8);
		rd(ADDR_T0_COUNT, a);
		ticks(300);
		rdc(ADDR_T1_COUNT, 8'hFF);
		rdc(ADDR_T1_COUNT, 8'hFE);
		wr(ADDR_T1_RELOAD, 8'h10);
		wr(ADDR_T1_CTRL, 8'h02);
		rdc(ADDR_T1_COUNT, 8'hFE);
		rd(ADDR_T0_COUNT, a);
		ticks(300);
		repeat (120) @(posedge i_ref_clk);
		rdc(ADDR_T1_COUNT, 8'hFD);
		chk("wide flags", 8'h00, {6'h00, f1, f0});
		finish_test();
	end
endmodule : testbench

// ### rtl/dual_programmable_down_timer.sv
// Purpose: Two 8-bit down timers, chainable to 16 bits, with event input and clock out
// Assumes: Source ticks and event input are synchronous to i_ref_clk
// Notes:   Source clock selection and interrupt enable logic live elsewhere
`timescale 1ns/1ns
module dual_programmable_down_timer #(
	parameter int LATCH_CYCLES = dual_timer_pkg::LATCH_RELEASE_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [dual_timer_pkg::ADDR_W-1:0] i_addr,
	input wire logic [dual_timer_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [dual_timer_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_t0_src_tick,
	input wire logic i_t1_src_tick,
	input wire logic i_tick_2048hz,
	input wire logic i_event_input_pin,
	output logic o_clock_out_pin,
	output logic o_inv_clock_out_pin,
	output logic o_t0_irq_flag,
	output logic o_t1_irq_flag,
	output logic [1:0] o_irq_level
);
	import dual_timer_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic wide_mode_r;
	logic out_channel_sel_r;
	logic out_clock_enable_r;
	logic event_count_mode_r;
	logic function_select_r;
	logic input_polarity_r;
	logic [1:0] t0_div_sel_r;
	logic [1:0] t1_div_sel_r;
	logic t0_continuous_r;
	logic t1_continuous_r;
	logic [7:0] t0_reload_r;
	logic [7:0] t1_reload_r;
	logic t0_run_r;
	logic t0_active_r;
	logic t1_run_r;
	logic t1_active_r;
	logic [1:0] irq_level_r;
	logic t0_irq_flag_r;
	logic t1_irq_flag_r;
	logic ev_prev_r;
	logic timer_clock_out_r;
	logic clock_out_pin_r;
	logic inv_clock_out_pin_r;
	logic [7:0] rdata_r;
	logic [7:0] hold_r;
	latch_state_t latch_state_r;
	logic [15:0] latch_cnt_r;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_prio = i_wr && (i_addr == ADDR_PRIORITY);
	wire wr_flag = i_wr && (i_addr == ADDR_IRQ_FLAG);
	wire wr_glb = i_wr && (i_addr == ADDR_GLOBAL);
	wire wr_t0 = i_wr && (i_addr == ADDR_T0_CTRL);
	wire wr_t1 = i_wr && (i_addr == ADDR_T1_CTRL);
	wire wr_rld0 = i_wr && (i_addr == ADDR_T0_RELOAD);
	wire wr_rld1 = i_wr && (i_addr == ADDR_T1_RELOAD);
	wire rd_cnt0 = i_rd && (i_addr == ADDR_T0_COUNT);
	wire rd_cnt1 = i_rd && (i_addr == ADDR_T1_COUNT);

	// ----------------------------------------------------------------
	// Event input conditioning
	// ----------------------------------------------------------------
	logic ev_filtered;

	event_noise_filter u_filter (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_tick(i_tick_2048hz),
		.i_level(i_event_input_pin),
		.o_level(ev_filtered)
	);

	wire ev_level = function_select_r ? ev_filtered : i_event_input_pin;
	wire ev_rise = ev_level && !ev_prev_r;
	wire ev_fall = !ev_level && ev_prev_r;
	wire ev_edge = input_polarity_r ? ev_rise : ev_fall;
	// Normal mode leaves the gate open whatever the polarity says
	wire width_gate = !function_select_r || (i_event_input_pin == input_polarity_r);

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	logic t0_div_tick;
	logic t1_div_tick;
	logic [7:0] t0_count;
	logic [7:0] t1_count;
	logic t0_zero;
	logic t1_zero;

	wire t0_cnt_en = event_count_mode_r ? (ev_edge && t0_run_r) :
		(t0_div_tick && t0_active_r && width_gate);
	wire t0_uf = t0_cnt_en && t0_zero;
	// Wide mode borrows from timer 0 and bypasses timer 1's prescaler
	wire t1_cnt_en = wide_mode_r ? t0_uf : (t1_div_tick && t1_active_r);
	wire t1_uf = t1_cnt_en && t1_zero;
	wire wide_uf = wide_mode_r && t1_uf;

	wire t0_load = wr_t0 && i_wdata[BIT_PRESET];
	wire t1_load = wr_t1 && i_wdata[BIT_PRESET] && !wide_mode_r;

	timer_channel8 u_t0 (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_src_tick(i_t0_src_tick),
		.i_div_sel(t0_div_sel_r),
		.o_div_tick(t0_div_tick),
		.i_count_en(t0_cnt_en),
		.i_load(t0_load),
		.i_reload(t0_reload_r),
		.o_count(t0_count),
		.o_zero(t0_zero)
	);

	timer_channel8 u_t1 (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_src_tick(i_t1_src_tick),
		.i_div_sel(t1_div_sel_r),
		.o_div_tick(t1_div_tick),
		.i_count_en(t1_cnt_en),
		.i_load(t1_load),
		.i_reload(t1_reload_r),
		.o_count(t1_count),
		.o_zero(t1_zero)
	);

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	// Event mode has no prescaled clock, so run changes apply at once
	wire t0_sync = event_count_mode_r || t0_div_tick;
	wire t1_sync = t1_div_tick;
	wire t0_stop = !t0_continuous_r && (wide_mode_r ? wide_uf : t0_uf);
	wire t1_stop = !t1_continuous_r && !wide_mode_r && t1_uf;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			t0_run_r <= 1'b0;
		else if (wr_t0)
			t0_run_r <= i_wdata[BIT_RUN];
		else if (t0_stop)
			t0_run_r <= 1'b0;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			t0_active_r <= 1'b0;
		else if (t0_stop)
			t0_active_r <= 1'b0;
		else if (t0_sync)
			t0_active_r <= t0_run_r;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || wide_mode_r)
			t1_run_r <= 1'b0;
		else if (wr_t1)
			t1_run_r <= i_wdata[BIT_RUN];
		else if (t1_stop)
			t1_run_r <= 1'b0;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || wide_mode_r)
			t1_active_r <= 1'b0;
		else if (t1_stop)
			t1_active_r <= 1'b0;
		else if (t1_sync)
			t1_active_r <= t1_run_r;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wide_mode_r <= 1'b0;
			out_channel_sel_r <= 1'b0;
			out_clock_enable_r <= 1'b0;
		end else if (wr_glb) begin
			wide_mode_r <= i_wdata[BIT_WIDE];
			out_channel_sel_r <= i_wdata[BIT_OUT_CHANNEL_SEL];
			out_clock_enable_r <= i_wdata[BIT_OUT_EN];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			event_count_mode_r <= 1'b0;
			function_select_r <= 1'b0;
			input_polarity_r <= 1'b0;
			t0_div_sel_r <= DIV_1;
			t0_continuous_r <= 1'b0;
		end else if (wr_t0) begin
			event_count_mode_r <= i_wdata[BIT_EVENT_MODE];
			function_select_r <= i_wdata[BIT_FUNC_SEL];
			input_polarity_r <= i_wdata[BIT_POLARITY];
			t0_div_sel_r <= i_wdata[BIT_DIV_HI:BIT_DIV_LO];
			t0_continuous_r <= i_wdata[BIT_CONT];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			t1_div_sel_r <= DIV_1;
			t1_continuous_r <= 1'b0;
		end else if (wr_t1) begin
			t1_div_sel_r <= i_wdata[BIT_DIV_HI:BIT_DIV_LO];
			t1_continuous_r <= i_wdata[BIT_CONT];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			t0_reload_r <= RELOAD_RST;
			t1_reload_r <= RELOAD_RST;
			irq_level_r <= 2'h0;
		end else begin
			if (wr_rld0)
				t0_reload_r <= i_wdata;
			if (wr_rld1)
				t1_reload_r <= i_wdata;
			if (wr_prio)
				irq_level_r <= i_wdata[BIT_LEVEL_HI:BIT_LEVEL_LO];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt flags, set wins over clear
	// ----------------------------------------------------------------
	wire t0_flag_set = t0_uf && !wide_mode_r;
	wire t0_flag_clr = wr_flag && i_wdata[BIT_T0_FLAG];
	wire t1_flag_clr = wr_flag && i_wdata[BIT_T1_FLAG];

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			t0_irq_flag_r <= 1'b0;
			t1_irq_flag_r <= 1'b0;
		end else begin
			t0_irq_flag_r <= t0_flag_set || (t0_irq_flag_r && !t0_flag_clr);
			t1_irq_flag_r <= t1_uf || (t1_irq_flag_r && !t1_flag_clr);
		end
	end

	// ----------------------------------------------------------------
	// Output clock
	// ----------------------------------------------------------------
	wire out_uf = (wide_mode_r || out_channel_sel_r) ? t1_uf : t0_uf;
	// Pins are registered so enabling never glitches mid-cycle
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ev_prev_r <= EVENT_IDLE_LEVEL;
			timer_clock_out_r <= 1'b0;
			clock_out_pin_r <= 1'b1;
			inv_clock_out_pin_r <= 1'b0;
		end else begin
			ev_prev_r <= ev_level;
			timer_clock_out_r <= timer_clock_out_r ^ out_uf;
			clock_out_pin_r <= out_clock_enable_r ? timer_clock_out_r : 1'b1;
			inv_clock_out_pin_r <= out_clock_enable_r ? !timer_clock_out_r : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// High byte read latch
	// ----------------------------------------------------------------
	wire latch_timeout = (latch_cnt_r == 16'(LATCH_CYCLES - 1));

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			latch_state_r <= LATCH_IDLE;
			hold_r <= COUNT_RST;
			latch_cnt_r <= 16'h0000;
		end else begin
			case (latch_state_r)
				LATCH_IDLE: begin
					latch_cnt_r <= 16'h0000;
					if (rd_cnt0 && wide_mode_r) begin
						hold_r <= t1_count;
						latch_state_r <= LATCH_HELD;
					end
				end
				LATCH_HELD: begin
					latch_cnt_r <= latch_cnt_r + 16'h0001;
					if (rd_cnt0 && wide_mode_r) begin
						hold_r <= t1_count;
						latch_cnt_r <= 16'h0000;
					end else if (rd_cnt1 || latch_timeout) begin
						latch_state_r <= LATCH_IDLE;
					end
				end
				default: latch_state_r <= LATCH_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [7:0] prio_rd = {4'h0, irq_level_r, 2'h0};
	wire [7:0] flag_rd = {t1_irq_flag_r, t0_irq_flag_r, 6'h00};
	wire [7:0] glb_rd = {3'h0, wide_mode_r, out_channel_sel_r, out_clock_enable_r, 2'h0};
	// Run reads 1 until the counter has really stopped; preset always reads 0
	wire [7:0] t0_rd = {event_count_mode_r, function_select_r, input_polarity_r, t0_div_sel_r,
		t0_continuous_r, 1'b0, t0_run_r || t0_active_r};
	wire [7:0] t1_rd = {3'h0, t1_div_sel_r, t1_continuous_r, 1'b0, t1_run_r || t1_active_r};
	wire [7:0] cnt1_rd = (latch_state_r == LATCH_HELD) ? hold_r : t1_count;

	wire [7:0] rd_mux =
		({8{i_addr == ADDR_PRIORITY}} & prio_rd) |
		({8{i_addr == ADDR_IRQ_FLAG}} & flag_rd) |
		({8{i_addr == ADDR_GLOBAL}} & glb_rd) |
		({8{i_addr == ADDR_T0_CTRL}} & t0_rd) |
		({8{i_addr == ADDR_T1_CTRL}} & t1_rd) |
		({8{i_addr == ADDR_T0_RELOAD}} & t0_reload_r) |
		({8{i_addr == ADDR_T1_RELOAD}} & t1_reload_r) |
		({8{i_addr == ADDR_T0_COUNT}} & t0_count) |
		({8{i_addr == ADDR_T1_COUNT}} & cnt1_rd);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= i_rd ? rd_mux : 8'h00;
	end

	assign o_rdata = rdata_r;
	assign o_clock_out_pin = clock_out_pin_r;
	assign o_inv_clock_out_pin = inv_clock_out_pin_r;
	assign o_t0_irq_flag = t0_irq_flag_r;
	assign o_t1_irq_flag = t1_irq_flag_r;
	assign o_irq_level = irq_level_r;
endmodule : dual_programmable_down_timer

// ### rtl/event_noise_filter.sv
// Purpose: Rejects short pulses on the event input
// Assumes: i_tick pulses once per falling edge of the 2048 Hz signal
// Notes:   A new level is passed on at the second tick after it appears
`timescale 1ns/1ns
module event_noise_filter (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_level,
	output logic o_level
);
	import dual_timer_pkg::*;

	logic level_r;
	logic [1:0] seen_r;

	assign o_level = level_r;

	// Any return to the old level before the second tick restarts the wait
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			level_r <= EVENT_IDLE_LEVEL;
			seen_r <= 2'h0;
		end else if (i_level == level_r) begin
			seen_r <= 2'h0;
		end else if (i_tick) begin
			if (seen_r == REJECT_EDGES - 2'h1) begin
				level_r <= i_level;
				seen_r <= 2'h0;
			end else begin
				seen_r <= seen_r + 2'h1;
			end
		end
	end
endmodule : event_noise_filter

// ### rtl/timer_channel8.sv
// Purpose: One 8-bit channel: source prescaler plus reloadable down counter
// Assumes: Source tick is a one-cycle pulse per falling edge of the source clock
// Notes:   Underflow is count enable while the count is zero; caller derives it
`timescale 1ns/1ns
module timer_channel8 (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_src_tick,
	input wire logic [1:0] i_div_sel,
	output logic o_div_tick,
	input wire logic i_count_en,
	input wire logic i_load,
	input wire logic [7:0] i_reload,
	output logic [7:0] o_count,
	output logic o_zero
);
	import dual_timer_pkg::*;

	logic [5:0] pre_r;
	logic [7:0] count_r;
	logic [5:0] div_mask;
	logic [7:0] count_nxt;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	assign div_mask = (i_div_sel == DIV_64) ? MASK_DIV_64 :
		(i_div_sel == DIV_16) ? MASK_DIV_16 :
		(i_div_sel == DIV_4) ? MASK_DIV_4 : MASK_DIV_1;
	assign o_div_tick = i_src_tick && ((pre_r & div_mask) == div_mask);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			pre_r <= 6'h00;
		else if (i_src_tick)
			pre_r <= pre_r + 6'h01;
	end

	// ----------------------------------------------------------------
	// Down counter
	// ----------------------------------------------------------------
	assign o_zero = (count_r == 8'h00);
	assign count_nxt = i_load ? i_reload :
		!i_count_en ? count_r :
		o_zero ? i_reload : count_r - 8'h01;
	assign o_count = count_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			count_r <= COUNT_RST;
		else
			count_r <= count_nxt;
	end
endmodule : timer_channel8

// ### shared/dual_timer_pkg.sv
// Purpose: Shared constants for the dual programmable down timer
// Assumes: 8-bit register port with 16-bit addresses, 20 MHz reference clock
// Notes:   Every offset and field position, the reload and count reset values, and timing counts live here
package dual_timer_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_PRIORITY = 16'hFF21;
	localparam logic [15:0] ADDR_IRQ_FLAG = 16'hFF25;
	localparam logic [15:0] ADDR_GLOBAL = 16'hFF30;
	localparam logic [15:0] ADDR_T0_CTRL = 16'hFF31;
	localparam logic [15:0] ADDR_T1_CTRL = 16'hFF32;
	localparam logic [15:0] ADDR_T0_RELOAD = 16'hFF33;
	localparam logic [15:0] ADDR_T1_RELOAD = 16'hFF34;
	localparam logic [15:0] ADDR_T0_COUNT = 16'hFF35;
	localparam logic [15:0] ADDR_T1_COUNT = 16'hFF36;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_EVENT_MODE = 7;
	localparam int BIT_FUNC_SEL = 6;
	localparam int BIT_POLARITY = 5;
	localparam int BIT_DIV_HI = 4;
	localparam int BIT_DIV_LO = 3;
	localparam int BIT_CONT = 2;
	localparam int BIT_PRESET = 1;
	localparam int BIT_RUN = 0;
	localparam int BIT_WIDE = 4;
	localparam int BIT_OUT_CHANNEL_SEL = 3;
	localparam int BIT_OUT_EN = 2;
	localparam int BIT_LEVEL_HI = 3;
	localparam int BIT_LEVEL_LO = 2;
	localparam int BIT_T1_FLAG = 7;
	localparam int BIT_T0_FLAG = 6;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] RELOAD_RST = 8'hFF;
	localparam logic [7:0] COUNT_RST = 8'hFF;
	localparam logic EVENT_IDLE_LEVEL = 1'b1;
	localparam logic [1:0] REJECT_EDGES = 2'h2;

	typedef enum logic [1:0] {
		DIV_1 = 2'b00,
		DIV_4 = 2'b01,
		DIV_16 = 2'b10,
		DIV_64 = 2'b11
	} div_sel_t;

	localparam logic [5:0] MASK_DIV_1 = 6'h00;
	localparam logic [5:0] MASK_DIV_4 = 6'h03;
	localparam logic [5:0] MASK_DIV_16 = 6'h0F;
	localparam logic [5:0] MASK_DIV_64 = 6'h3F;

	typedef enum logic {
		LATCH_IDLE = 1'b0,
		LATCH_HELD = 1'b1
	} latch_state_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int LATCH_RELEASE_NS = 730000;
	localparam int LATCH_RELEASE_CYCLES = (LATCH_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dual_timer_pkg
